// file: logic/wdtwk_core.sv
// Watchdog timer with sleep (halt) wake-up control
// Notes on behaviour
// RULE_01 - Wake on reset pin, port edge, interrupt, overflow; code ignores pin two edges
// RULE_02 - Reset pin wake gives full system reset
// RULE_03 - Halted timeout sets flag, resets PC/SP only
// RULE_04 - Powerdown flag: clear at power-up/clear, halt sets
// RULE_05 - Enabled port pin falling edge wakes device; code never wakes on pin two, even when enabled
// RULE_06 - Port wake resumes after halt, no reset
// RULE_07 - Disabled interrupt wake resumes, serviced later
// RULE_08 - Flag pending at halt cannot wake
// RULE_09 - Counter runs on low-speed RC oscillator ticks
// RULE_10 - Select code picks 2^8 to 2^18 timeout
// RULE_11 - Key 10101 disables, 01010 enables watchdog
// RULE_12 - Bad key resets after delay, sets flag
// RULE_13 - Flag register bits 7..4 read zero
// RULE_14 - Bit 3 records bad reset-control key
// RULE_15 - Processor stopped; wake waits oscillator settle
// RULE_16 - Halt clears counter, counting continues if enabled
// RULE_17 - Halt sets powerdown flag, clears timeout flag
// RULE_18 - Clear instruction clears counter
// RULE_19 - Running timeout resets device, sets flag
// RULE_20 - Counter restarts at zero, overflows at ratio
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module wdtwk_core import wdtwk_pkg::*; #(
	parameter int PORT_W = 8,
	parameter int IRQ_W = 4,
	parameter int KEY_DELAY = WDTWK_KEY_DELAY_CYC,
	parameter int OSC_WAIT = WDTWK_OSC_WAIT_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic power_up,
	input wire logic low_speed_rc_osc_tick,
	input wire logic ext_reset_pin_n,
	input wire logic [PORT_W-1:0] port_a_in,
	input wire logic [IRQ_W-1:0] irq_flag,
	input wire logic [IRQ_W-1:0] irq_enable,
	input wire logic halt_exec,
	input wire logic clr_wdt_exec,
	input wire logic rstc_key_bad,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	output logic cpu_stopped,
	output wdtwk_wake_s wake,
	output logic [IRQ_W-1:0] irq_service
);
	logic [7:0] control;
	logic [7:0] next_control;
	logic [3:0] flags;
	logic [3:0] next_flags;
	logic [7:0] wake_en;
	logic [7:0] next_wake_en;
	logic to_flag;
	logic next_to_flag;
	logic pd_flag;
	logic next_pd_flag;
	logic [WDTWK_CNT_W-1:0] count;
	logic [WDTWK_CNT_W-1:0] next_count;
	logic [PORT_W-1:0] port_prev;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] next_irq_mask;
	logic [IRQ_W-1:0] irq_held;
	logic [IRQ_W-1:0] next_irq_held;
	wdtwk_mode_e mode;
	wdtwk_mode_e next_mode;
	wdtwk_wake_s pend;
	wdtwk_wake_s next_pend;
	wdtwk_wake_s next_wake;
	logic [15:0] timer;
	logic [15:0] next_timer;
	logic key_bad_armed;
	logic next_key_bad_armed;
	logic [7:0] next_rdata;
	logic [4:0] key;
	logic [2:0] sel;
	logic overflow;
	logic wdt_on;
	logic key_bad;
	logic port_wake;
	logic irq_wake;
	logic wake_req;
	logic [WDTWK_CNT_W-1:0] limit;
	logic [PORT_W-1:0] port_mask;

	assign key = control[WDTWK_KEY_LSB +: 5];
	assign sel = control[WDTWK_SEL_LSB +: 3];
	assign wdt_on = (key == WDTWK_KEY_ENABLE); // RULE_11
	assign key_bad = (key != WDTWK_KEY_ENABLE) && (key != WDTWK_KEY_DISABLE); // RULE_12
	assign cpu_stopped = (mode != WDTWK_RUN); // RULE_15

	always_comb begin
		unique case (sel) // RULE_10
			3'h0: limit = 19'h00100;
			3'h1: limit = 19'h00400;
			3'h2: limit = 19'h01000;
			3'h3: limit = 19'h04000;
			3'h4: limit = 19'h08000;
			3'h5: limit = 19'h10000;
			3'h6: limit = 19'h20000;
			3'h7: limit = 19'h40000;
		endcase
	end
	// At or above, so a ratio shortened mid-count still trips instead of waiting for wrap
	assign overflow = wdt_on && low_speed_rc_osc_tick && (count >= limit - 19'h00001); // RULE_20

	always_comb begin
		port_mask = wake_en[PORT_W-1:0];
		port_mask[WDTWK_PIN_TWO] = 1'b0; // RULE_01
	end
	// Falling edge on an enabled pin other than pin two
	assign port_wake = |(port_prev & ~port_a_in & port_mask); // RULE_05
	// Only flags that rose after the halt may wake
	assign irq_wake = |(irq_flag & ~irq_held); // RULE_08
	assign wake_req = port_wake || irq_wake || !ext_reset_pin_n || overflow; // RULE_01

	always_comb begin
		next_control = control;
		next_wake_en = wake_en;
		next_flags = flags;
		next_to_flag = to_flag;
		next_pd_flag = pd_flag;
		next_count = count;
		next_mode = mode;
		next_pend = pend;
		next_timer = timer;
		next_irq_held = irq_held;
		next_irq_mask = irq_mask;
		next_key_bad_armed = key_bad_armed;
		next_wake = '0;
		next_rdata = 8'h00;
		if (reg_write && reg_addr == WDTWK_ADDR_CONTROL)
			next_control = reg_wdata;
		if (reg_write && reg_addr == WDTWK_ADDR_WAKE_EN)
			next_wake_en = reg_wdata;
		if (reg_write && reg_addr == WDTWK_ADDR_FLAGS)
			next_flags = reg_wdata[3:0];
		if (rstc_key_bad)
			next_flags[WDTWK_FLAG_RESET_CONTROL_KEY_FLAG] = 1'b1; // RULE_14
		if (wdt_on && low_speed_rc_osc_tick)
			next_count = overflow ? '0 : count + 19'h00001; // RULE_09
		if (clr_wdt_exec) begin
			next_count = '0; // RULE_18
			next_pd_flag = 1'b0; // RULE_04
		end
		// Bad key: counter held clear, reset issued once delay expires
		if (key_bad) begin
			next_count = '0;
			if (!key_bad_armed) begin
				next_key_bad_armed = 1'b1;
				next_timer = 16'(KEY_DELAY);
			end else if (timer != 16'h0000) begin
				next_timer = timer - 16'h0001;
			end else begin
				next_flags[WDTWK_FLAG_WRF] = 1'b1; // RULE_12
				next_wake.full_reset = 1'b1; // RULE_12
				next_control = WDTWK_CONTROL_RESET;
				next_key_bad_armed = 1'b0;
				next_mode = WDTWK_RUN;
			end
		end else begin
			next_key_bad_armed = 1'b0;
		end
		irq_service = irq_flag & irq_enable & ~irq_mask; // RULE_07
		next_irq_mask = irq_mask & ~irq_enable; // RULE_07
		unique case (mode)
			WDTWK_RUN: begin
				if (overflow) begin
					next_to_flag = 1'b1; // RULE_19
					next_wake.full_reset = 1'b1; // RULE_19
				end else if (halt_exec && !key_bad) begin
					next_count = '0; // RULE_16
					next_pd_flag = 1'b1; // RULE_17
					next_to_flag = 1'b0; // RULE_17
					next_irq_held = irq_flag; // RULE_08
					next_mode = WDTWK_HALTED;
				end
			end
			WDTWK_HALTED: begin
				if (wake_req) begin
					next_pend = '0;
					if (!ext_reset_pin_n) begin
						next_pend.full_reset = 1'b1; // RULE_02
					end else if (overflow) begin
						next_to_flag = 1'b1; // RULE_03
						next_pend.pc_sp_reset = 1'b1; // RULE_03
					end else begin
						next_pend.resume = 1'b1; // RULE_06
						next_irq_mask = irq_flag & ~irq_held & ~irq_enable; // RULE_07
					end
					next_timer = 16'(OSC_WAIT);
					next_mode = WDTWK_WAKING;
				end
			end
			WDTWK_WAKING: begin
				// Oscillator restart is modelled as a fixed settle count
				if (timer != 16'h0000) begin
					next_timer = timer - 16'h0001; // RULE_15
				end else begin
					next_wake = pend;
					next_mode = WDTWK_RUN;
				end
			end
		endcase
		if (!ext_reset_pin_n && mode == WDTWK_RUN)
			next_wake.full_reset = 1'b1;
		if (reg_read) begin
			unique case (reg_addr)
				WDTWK_ADDR_CONTROL: next_rdata = control;
				WDTWK_ADDR_FLAGS: next_rdata = {4'h0, flags}; // RULE_13
				WDTWK_ADDR_STATUS: next_rdata = {5'h00, cpu_stopped, pd_flag, to_flag};
				WDTWK_ADDR_WAKE_EN: next_rdata = wake_en;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			control <= WDTWK_CONTROL_RESET;
			wake_en <= WDTWK_WAKE_EN_RESET;
			flags <= WDTWK_FLAGS_RESET;
			to_flag <= 1'b0;
			pd_flag <= 1'b0;
			count <= '0;
			mode <= WDTWK_RUN;
			pend <= '0;
			timer <= 16'h0000;
			irq_held <= '0;
			irq_mask <= '0;
			key_bad_armed <= 1'b0;
			wake <= '0;
			reg_rdata <= 8'h00;
			port_prev <= '1;
		end else begin
			control <= next_control;
			wake_en <= next_wake_en;
			flags <= next_flags;
			to_flag <= next_to_flag;
			pd_flag <= power_up ? 1'b0 : next_pd_flag; // RULE_04
			count <= next_count;
			mode <= next_mode;
			pend <= next_pend;
			timer <= next_timer;
			irq_held <= next_irq_held;
			irq_mask <= next_irq_mask;
			key_bad_armed <= next_key_bad_armed;
			wake <= next_wake;
			reg_rdata <= next_rdata;
			port_prev <= port_a_in;
		end
	end

	AST_HALT_FLAGS: assert property (@(posedge clk) disable iff (!rst_n) // RULE_17
		(mode == WDTWK_RUN && halt_exec && !overflow && !key_bad && !power_up) |=> (pd_flag && !to_flag && count == '0))
		else $error("halt did not set powerdown and clear timeout");
	AST_CLR_COUNT: assert property (@(posedge clk) disable iff (!rst_n) // RULE_18
		clr_wdt_exec |=> (count == '0))
		else $error("clear instruction left counter nonzero");
	AST_PD_CLR: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
		(clr_wdt_exec || power_up) |=> !pd_flag)
		else $error("powerdown flag not cleared");
	AST_DISABLED_STILL: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
		(key == WDTWK_KEY_DISABLE && !reg_write && !clr_wdt_exec && !halt_exec) |=> $stable(count))
		else $error("disabled watchdog counted");
	AST_RUN_TIMEOUT: assert property (@(posedge clk) disable iff (!rst_n) // RULE_19
		(mode == WDTWK_RUN && overflow) |=> (to_flag && wake.full_reset))
		else $error("running timeout did not reset");
	AST_SLEEP_TIMEOUT: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
		(mode == WDTWK_HALTED && overflow && ext_reset_pin_n && !key_bad) |=> (to_flag && pend.pc_sp_reset && !pend.full_reset))
		else $error("halted timeout handled wrongly");
	AST_PORT_WAKE: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
		(mode == WDTWK_HALTED && port_wake && !key_bad) |=> (mode == WDTWK_WAKING))
		else $error("port edge did not wake");
	AST_SETTLE: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
		(mode == WDTWK_HALTED ##1 mode == WDTWK_WAKING) |-> cpu_stopped [*2])
		else $error("processor released before settle");
	AST_PENDING_IRQ: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
		(mode == WDTWK_HALTED && !(|(irq_flag & ~irq_held)) && !port_wake && ext_reset_pin_n && !overflow && !key_bad)
		|=> (mode == WDTWK_HALTED))
		else $error("held interrupt caused wake");
	AST_RST_ZERO: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
		$past(reg_read && reg_addr == WDTWK_ADDR_FLAGS) |-> (reg_rdata[7:4] == 4'h0))
		else $error("flag register upper bits nonzero");

	AST_STAY_HALTED: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
		(mode == WDTWK_HALTED && !wake_req && !key_bad) |=> (mode == WDTWK_HALTED))
		else $error("left halt with no wake cause");

	AST_WAKE_LEAVES: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
		(mode == WDTWK_HALTED && wake_req && !key_bad) |=> (mode == WDTWK_WAKING))
		else $error("wake cause ignored while halted");

	AST_EXT_FULL: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
		(mode == WDTWK_HALTED && !ext_reset_pin_n && !key_bad) |=> (pend.full_reset && !pend.pc_sp_reset && !pend.resume))
		else $error("reset pin wake not a full reset");

	AST_PORT_RESUME: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
		(mode == WDTWK_HALTED && port_wake && ext_reset_pin_n && !overflow && !key_bad)
		|=> (pend.resume && !pend.full_reset && !pend.pc_sp_reset))
		else $error("port wake did not resume");

	AST_WAKE_AFTER_SETTLE: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
		(mode == WDTWK_WAKING && timer == 16'h0000 && !key_bad) |=> (mode == WDTWK_RUN && wake == $past(pend)))
		else $error("settle end did not release");

	AST_NO_EARLY_WAKE: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
		(mode == WDTWK_WAKING && timer != 16'h0000 && !key_bad) |=> (wake == '0 && cpu_stopped))
		else $error("wake pulse before settle");

	AST_HALT_STOPS: assert property (@(posedge clk) disable iff (!rst_n) // RULE_16
		(mode == WDTWK_RUN && halt_exec && !overflow && !key_bad) |=> cpu_stopped)
		else $error("halt did not stop processor");

	AST_HALT_COUNTS: assert property (@(posedge clk) disable iff (!rst_n) // RULE_16
		(mode == WDTWK_HALTED && wdt_on && low_speed_rc_osc_tick && !overflow && !clr_wdt_exec)
		|=> (count == $past(count) + 19'h00001))
		else $error("enabled counter stopped in halt");

	AST_COUNT_WRAP: assert property (@(posedge clk) disable iff (!rst_n) // RULE_20
		overflow |=> (count == '0))
		else $error("counter not restarted after overflow");

	AST_KEY_RESET: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
		(mode == WDTWK_RUN && key_bad && key_bad_armed && timer == 16'h0000)
		|=> (wake.full_reset && flags[WDTWK_FLAG_WRF] && control == WDTWK_CONTROL_RESET))
		else $error("bad key reset missing");

	AST_KEY_CLEARS: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
		key_bad |=> (count == '0))
		else $error("counter ran under bad key");

	AST_RESET_CONTROL_KEY_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n) // RULE_14
		rstc_key_bad |=> flags[WDTWK_FLAG_RESET_CONTROL_KEY_FLAG])
		else $error("reset control key flag not set");

	AST_WAKE_ONEHOT: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
		$onehot0(wake))
		else $error("more than one wake kind at once");

	AST_RESUME_KEEPS_TO: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
		(mode == WDTWK_HALTED && wake_req && ext_reset_pin_n && !overflow && !key_bad) |=> $stable(to_flag))
		else $error("resume wake changed timeout flag");

	AST_MASK_CLEARS: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
		(|(irq_mask & irq_enable)) |=> !(|(irq_mask & $past(irq_enable))))
		else $error("enabled interrupt still masked");

	AST_HALT_HOLDS_IRQ: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
		(mode == WDTWK_RUN && halt_exec && !overflow && !key_bad) |=> (irq_held == $past(irq_flag)))
		else $error("pending flags not captured at halt");

	AST_RUN_STAYS: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
		(mode == WDTWK_RUN && !halt_exec) |=> !cpu_stopped)
		else $error("processor stopped without halt");
endmodule

// file: logic/wdtwk_pkg.sv
// Package with register map, field layout, reset values and timing counts
package wdtwk_pkg;
	localparam logic [1:0] WDTWK_ADDR_CONTROL = 2'h0;
	localparam logic [1:0] WDTWK_ADDR_FLAGS = 2'h1;
	localparam logic [1:0] WDTWK_ADDR_STATUS = 2'h2;
	localparam logic [1:0] WDTWK_ADDR_WAKE_EN = 2'h3;
	localparam int WDTWK_KEY_LSB = 3;
	localparam int WDTWK_SEL_LSB = 0;
	localparam logic [4:0] WDTWK_KEY_DISABLE = 5'h15;
	localparam logic [4:0] WDTWK_KEY_ENABLE = 5'h0a;
	localparam logic [7:0] WDTWK_CONTROL_RESET = 8'h53;
	localparam logic [3:0] WDTWK_FLAGS_RESET = 4'h0;
	localparam logic [7:0] WDTWK_WAKE_EN_RESET = 8'h00;
	localparam int WDTWK_FLAG_WRF = 0;
	localparam int WDTWK_FLAG_RESET_CONTROL_KEY_FLAG = 3;
	localparam int WDTWK_STAT_TO = 0;
	localparam int WDTWK_STAT_PDF = 1;
	localparam int WDTWK_STAT_ASLEEP = 2;
	localparam int WDTWK_PIN_TWO = 2;
	localparam int WDTWK_CNT_W = 19;
	// Key reset delay in ns, and its cycle count at 50 MHz
	localparam int WDTWK_KEY_DELAY_NS = 1000;
	localparam int WDTWK_CLK_NS = 20;
	localparam int WDTWK_KEY_DELAY_CYC = (WDTWK_KEY_DELAY_NS + WDTWK_CLK_NS - 1) / WDTWK_CLK_NS;
	localparam int WDTWK_OSC_WAIT_CYC = 16;
	typedef enum logic [1:0] {WDTWK_RUN, WDTWK_HALTED, WDTWK_WAKING} wdtwk_mode_e;
	typedef struct packed {
		logic pc_sp_reset;
		logic full_reset;
		logic resume;
	} wdtwk_wake_s;
endpackage

// file: dv/wdtwk_core_tb_top.sv
// Directed testbench for the watchdog and wake-up block
`timescale 1ns/1ps
module wdtwk_core_tb_top import wdtwk_pkg::*;;
	localparam int KD = 3;
	localparam int OW = 2;
	logic clk, rst_n, low_speed_rc_osc_tick, ext_n, reg_write, reg_read;
	logic [3:0] ev, irq_flag, irq_enable, irq_service;
	logic [7:0] port_a, reg_wdata, reg_rdata, d;
	logic [1:0] reg_addr;
	logic cpu_stopped;
	wdtwk_wake_s wake;
	logic [2:0] w;
	int num_errors, n_checks, n;
	wdtwk_core #(.KEY_DELAY(KD), .OSC_WAIT(OW)) uut (.clk(clk), .rst_n(rst_n), .power_up(ev[2]),
		.low_speed_rc_osc_tick(low_speed_rc_osc_tick), .ext_reset_pin_n(ext_n), .port_a_in(port_a), .irq_flag(irq_flag),
		.irq_enable(irq_enable), .halt_exec(ev[0]), .clr_wdt_exec(ev[1]), .rstc_key_bad(ev[3]),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .cpu_stopped(cpu_stopped), .wake(wake), .irq_service(irq_service));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Oscillator tick every other cycle, so one tick is two clocks
	always @(posedge clk) low_speed_rc_osc_tick <= rst_n ? ~low_speed_rc_osc_tick : 1'b0;
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	task rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task fire(input logic [3:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 4'h0;
		#1;
	endtask
	// Cycles until any wake pulse, or lim when none came
	task wait_wake(input int lim);
		n = 0;
		w = 3'h0;
		while (n < lim && w === 3'h0) begin
			@(posedge clk);
			#1 w = wake;
			n++;
		end
	endtask
	task end_of_test();
		$display("Checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#300us;
		num_errors++;
		end_of_test();
	end
	initial begin
		{rst_n, reg_write, reg_read, ev, irq_flag, irq_enable} = '0;
		{reg_wdata, reg_addr} = '0;
		port_a = 8'hff;
		ext_n = 1'b1;
		num_errors = 0;
		n_checks = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(2'h0, d); chk(d, 8'h53);
		rd(2'h1, d); chk(d, 8'h00);
		rd(2'h2, d); chk(d, 8'h00);
		wr(2'h1, 8'hff); rd(2'h1, d); chk(d, 8'h0f);
		wr(2'h1, 8'h00); fire(4'h8); rd(2'h1, d); chk(d, 8'h08);
		wr(2'h1, 8'h00);
		// Pin two and an already pending request must not wake
		fire(4'h2); wr(2'h3, 8'h06); irq_flag[1] <= 1'b1; irq_enable[1] <= 1'b1;
		fire(4'h1); chk(cpu_stopped, 1);
		rd(2'h2, d); chk(d, 8'h06);
		port_a[2] <= 1'b0; wait_wake(20); chk(w, 3'h0);
		chk(cpu_stopped, 1);
		port_a[1] <= 1'b0; wait_wake(40); chk(w, 3'h1);
		chk(n >= OW, 1);
		chk(cpu_stopped, 0);
		port_a <= 8'hff; irq_flag <= 4'h0; irq_enable <= 4'h0;
		rd(2'h2, d); chk(d, 8'h02);
		fire(4'h1); irq_flag[0] <= 1'b1; wait_wake(40); chk(w, 3'h1);
		chk(irq_service, 4'h0);
		irq_enable[0] <= 1'b1; @(posedge clk); #1 chk(irq_service, 4'h1);
		irq_flag <= 4'h0; irq_enable <= 4'h0;
		fire(4'h4); rd(2'h2, d); chk(d, 8'h00);
		// Halted overflow for the two shortest ratios
		for (int s = 0; s < 2; s++) begin
			fire(4'h2); wr(2'h0, 8'h50 | s); fire(4'h1);
			wait_wake(2200); chk(w, 3'h4);
			chk(n > (512 << (2 * s)) - 20 && n < (512 << (2 * s)) + 30, 1);
			rd(2'h2, d); chk(d, 8'h03);
		end
		fire(4'h2); rd(2'h2, d); chk(d[1], 0);
		wr(2'h0, 8'h50);
		// Regular clears hold off a running overflow, then it fires
		for (int i = 0; i < 4; i++) begin
			fire(4'h2); wait_wake(300); chk(w, 3'h0);
		end
		fire(4'h2); wait_wake(600); chk(w, 3'h2);
		chk(n > 490 && n < 530, 1);
		rd(2'h2, d); chk(d[0], 1);
		wr(2'h0, 8'ha8); rd(2'h0, d); chk(d, 8'ha8);
		wait_wake(700); chk(w, 3'h0);
		fire(4'h1); ext_n <= 1'b0; wait_wake(40); chk(w, 3'h2);
		ext_n <= 1'b1;
		repeat (OW + 4) @(posedge clk);
		wr(2'h1, 8'h00); wr(2'h0, 8'hf8); wait_wake(20); chk(w, 3'h2);
		chk(n >= KD, 1);
		rd(2'h1, d); chk(d, 8'h01);
		rd(2'h0, d); chk(d, 8'h53);
		end_of_test();
	end
endmodule
